// ==== eepin_asserts.sv ====
// Concurrent checks on the pin front end, seen from its top-level ports.
// Assumes a single clock domain and the bench's shortened power-up count.
module eepin_asserts #(
  parameter int POWERUP_CYCLES = 50  // Readiness delay in cycles
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       por_ok_i,
  input  wire logic       scl_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe_o,
  input  wire logic       write_busy_i,
  input  wire logic [7:0] rx_data_o,
  input  wire logic       rx_valid_o,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_take_o,
  input  wire logic       selected_o,
  input  wire logic       reading_o,
  input  wire logic       stop_o,
  input  wire logic       ready_o
);
  // ----------------------------------------
  // Supply-good cycle counter
  // ----------------------------------------
  logic [31:0] por_cnt;       // Cycles with supply good
  logic [31:0] next_por_cnt;  // Next count
  // Saturates so a long run never wraps back into the window
  always_comb begin
    next_por_cnt = por_cnt;
    if (!por_ok_i) begin
      next_por_cnt = 32'h0;
    end else if (por_cnt != 32'hFFFFFFFF) begin
      next_por_cnt = por_cnt + 32'h1;
    end
  end
  // Register the count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_cnt <= 32'h0;
    end else begin
      por_cnt <= next_por_cnt;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  open_drain_a: assert property (!sda_o)
    else $error("data output value not low");
  quiet_unready_a: assert property (!ready_o |-> !sda_oe_o && !selected_o)
    else $error("bus activity while not ready");
  scl_low_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  ready_delay_a: assert property ($rose(ready_o) |->
    por_cnt >= POWERUP_CYCLES && por_cnt <= POWERUP_CYCLES + 6)
    else $error("ready rose outside power-up window");
  por_drop_a: assert property ($fell(por_ok_i) |-> ##[1:4] !ready_o)
    else $error("ready held after supply loss");
  busy_refuse_a: assert property (write_busy_i [*3] |-> !$rose(selected_o))
    else $error("selected while write busy");
  take_pulse_a: assert property (tx_take_o |-> reading_o ##1 !tx_take_o)
    else $error("take pulse too long or outside a read");
  stop_pulse_a: assert property (stop_o |=> !stop_o)
    else $error("stop pulse too long");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("received byte dropped while stalled");
endmodule

bind eepin_top eepin_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (
  .clk_i, .nrst_i, .por_ok_i, .scl_i, .sda_o, .sda_oe_o, .write_busy_i, .rx_data_o,
  .rx_valid_o, .rx_ready_i, .tx_take_o, .selected_o, .reading_o, .stop_o, .ready_o
);

// ==== eepin_bench.sv ====
// Self-checking bench for the pin front end, with a behavioural master.
// Assumes the checker is bound through its own file.
module eepin_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int         PU    = 50;              // Shortened readiness delay
  localparam logic [3:0] TYPE  = 4'h6;            // Arbitrary device-type code
  localparam logic [7:0] ADR_W = {TYPE, 4'h0};    // Write, select 000
  localparam logic [7:0] ADR_R = {TYPE, 4'h1};    // Read, select 000
  logic       clk_i        = 1'b0;
  logic       nrst_i       = 1'b0;
  logic       por_ok_i     = 1'b1;
  logic [2:0] select_i     = 3'h0;   // Zero stands for floating pins
  logic       wp_i         = 1'b0;   // Zero stands for a floating pin
  logic       write_busy_i = 1'b0;
  logic       rx_ready_i   = 1'b1;
  logic [7:0] tx_data_i    = 8'h5A;
  logic [7:0] rx_data_o;
  logic       sda_o, sda_oe_o, rx_valid_o, rx_first_o, tx_take_o;
  logic       selected_o, reading_o, stop_o, ready_o, m_low;
  wire  logic scl_i;
  wire  logic sda_i;
  logic [8:0] rxq[$];                // First flag and byte taken by consumer
  int         n_tests, bad_count, n_takes, n_stops;
  // Pull-up wire: low when either side pulls
  assign sda_i = (sda_oe_o ? sda_o : 1'b1) & ~m_low;
  always #10 clk_i = ~clk_i;
  eepin_top #(.POWERUP_CYCLES(PU), .TYPE_CODE(TYPE)) dut (
    .clk_i, .nrst_i, .por_ok_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .select_i, .wp_i,
    .write_busy_i, .rx_data_o, .rx_valid_o, .rx_first_o, .rx_ready_i, .tx_data_i,
    .tx_take_o, .selected_o, .reading_o, .stop_o, .ready_o);
  eepin_master master (.sda_i(sda_i), .scl_o(scl_i), .low_o(m_low));
  // Consumer log, read-byte source and event counts
  always @(posedge clk_i) begin
    if ((rx_valid_o && rx_ready_i) === 1'b1) rxq.push_back({rx_first_o, rx_data_o});
    if (tx_take_o === 1'b1) begin
      n_takes++;
      tx_data_i <= tx_data_i + 8'h11;
    end
    if (stop_o === 1'b1) n_stops++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address only, then stop; judges the acknowledge
  task automatic probe(input logic [7:0] a, input logic exp);
    logic ack;
    master.start();
    master.put(a, ack);
    master.stop();
    check({7'h00, ack}, {7'h00, exp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_powerup();
    repeat (PU - 4) @(posedge clk_i);
    check({7'h00, ready_o}, 8'h00);
    check({7'h00, sda_oe_o}, 8'h00);
    repeat (12) @(posedge clk_i);
    check({7'h00, ready_o}, 8'h01);
    $display("powerup test done");
  endtask
  task automatic t_select();
    @(posedge clk_i) select_i <= 3'h5;
    for (int i = 0; i < 8; i++) probe({TYPE, 3'(i), 1'b0}, i == 5);
    probe({4'h9, 3'h5, 1'b0}, 1'b0);
    @(posedge clk_i) select_i <= 3'h0;
    probe(ADR_W, 1'b1);
    $display("select test done");
  endtask
  // Two address bytes and two data bytes, consumer stalled meanwhile
  task automatic t_write(input logic prot);
    logic       ack;
    logic [7:0] b[4] = '{8'h01, 8'h23, 8'hC4, 8'h3E};
    int         s0 = n_stops;
    rxq.delete();
    @(posedge clk_i) wp_i <= prot;
    rx_ready_i <= 1'b0;
    master.start();
    master.put(ADR_W, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      master.put(b[i], ack);
      check({7'h00, ack}, {7'h00, i < 2 || !prot});
    end
    master.stop();
    repeat (20) @(posedge clk_i);
    if (!prot) begin
      check(8'(n_stops - s0), 8'h01);
      check(8'(rxq.size()), 8'h00);
      @(posedge clk_i) rx_ready_i <= 1'b1;
      @(posedge clk_i) rx_ready_i <= 1'b0;  // Holds a shown byte
      repeat (3) @(posedge clk_i);
      rx_ready_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      check(8'(rxq.size()), 8'h04);
      for (int i = 0; i < 4; i++) check(rxq[i][7:0], b[i]);
      for (int i = 0; i < 4; i++) check({7'h00, rxq[i][8]}, {7'h00, i < 3});
    end
    @(posedge clk_i) rx_ready_i <= 1'b1;
    wp_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    $display("write test done");
  endtask
  task automatic t_busy();
    @(posedge clk_i) write_busy_i <= 1'b1;
    probe(ADR_W, 1'b0);
    @(posedge clk_i) write_busy_i <= 1'b0;
    probe(ADR_W, 1'b1);
    $display("busy test done");
  endtask
  task automatic t_read();
    logic       ack;
    logic [7:0] d;
    int         k = n_takes;
    @(posedge clk_i) tx_data_i <= 8'h5A;
    master.start();
    master.put(ADR_R, ack);
    check({7'h00, ack}, 8'h01);
    master.get(1'b1, d);
    check(d, 8'h5A);
    master.get(1'b0, d);
    check(d, 8'h6B);
    master.stop();
    check(8'(n_takes - k), 8'h02);
    $display("read test done");
  endtask
  task automatic t_glitch();
    int s;
    master.set_glitch(1'b1);
    probe(ADR_W, 1'b1);
    master.set_glitch(1'b0);
    s = n_stops;
    master.blip();
    repeat (20) @(posedge clk_i);
    check(8'(n_stops - s), 8'h00);
    $display("glitch test done");
  endtask
  task automatic t_por();
    @(posedge clk_i) por_ok_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({7'h00, ready_o}, 8'h00);
    probe(ADR_W, 1'b0);
    @(posedge clk_i) por_ok_i <= 1'b1;
    for (int i = 0; i < 100 && ready_o !== 1'b1; i++) @(posedge clk_i);
    probe(ADR_W, 1'b1);
    $display("por test done");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_powerup();
    t_select();
    t_write(1'b0);
    t_write(1'b1);
    t_busy();
    t_read();
    t_glitch();
    t_por();
    wrap_up();
  end
  // Watchdog, about three times the expected run
  initial begin
    #600000;
    bad_count++;
    wrap_up();
  end
endmodule

// ==== eepin_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
module eepin_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("eepin_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];      // Word storage
  logic [AW:0]      wr_ptr;           // Write pointer with wrap bit
  logic [AW:0]      rd_ptr;           // Read pointer with wrap bit
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // Flags derived from pointers; full when wrap bits differ and the index bits match
  always_comb begin
    in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid_o = (wr_ptr != rd_ptr);
    out_data_o  = mem[rd_ptr[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Memory write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ==== eepin_master.sv ====
// Behavioural two-wire bus master; the only source of the bus clock.
// Assumes the bench resolves the pulled-up data wire from all drivers.
module eepin_master (
  input  wire logic sda_i,  // Resolved data wire
  output logic      scl_o,  // Bus clock
  output logic      low_o   // High while pulling data low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bit slots on a 160 ns tick
  // ----------------------------------------
  bit glitch = 1'b0;  // Dips the clock 100 ns inside the high phase of each bit slot
  initial begin
    scl_o = 1'b1;
    low_o = 1'b0;
  end
  // Phases span two ticks: even one tick would outlast the noise filter
  task automatic set_glitch(input bit g);
    glitch = g;
  endtask
  // Keeps every pin change 5 ns clear of the sampling clock edge
  task automatic align();
    #((35 - ($time % 20)) % 20);
  endtask
  // One bit: data moved mid-low, sampled mid-high
  task automatic slot(input logic b, output logic r);
    scl_o = 1'b0;
    #160 low_o = ~b;
    #160 scl_o = 1'b1;
    if (glitch) begin
      #30 scl_o = 1'b0;
      #100 scl_o = 1'b1;
      #30;
    end else begin
      #160;
    end
    r = sda_i;
    #160;
  endtask
  // Start, usable as repeated start too
  task automatic start();
    align();
    scl_o = 1'b0;
    #160 low_o = 1'b0;
    #160 scl_o = 1'b1;
    #160 low_o = 1'b1;
    #320;
  endtask
  // Stop leaves the bus idle with the clock standing high
  task automatic stop();
    scl_o = 1'b0;
    #160 low_o = 1'b1;
    #160 scl_o = 1'b1;
    #160 low_o = 1'b0;
    #320;
  endtask
  // Short data dip while idle: a false start and stop if unfiltered
  task automatic blip();
    align();
    low_o = 1'b1;
    #100 low_o = 1'b0;
    #300;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], r);
    slot(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, r);
      d[i] = r;
    end
    slot(~more, r);
  endtask
endmodule

// ==== eepin_pkg.sv ====
// Package of constants for the two-wire EEPROM pin front end.
// Assumes a 50 MHz system clock; all times are converted to cycles here.
package eepin_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ          = 50;       // System clock rate
  localparam int GLITCH_NS        = 100;      // Widest pulse to reject
  localparam int GLITCH_CYC       = (GLITCH_NS * CLK_MHZ + 999) / 1000 + 1; // Must exceed
  localparam int POWERUP_US       = 1000;     // Power-up to ready, 1 ms
  localparam int POWERUP_CYC      = (POWERUP_US * CLK_MHZ) - 4; // Less sync and output flops
  // ----------------------------------------
  // Address layout
  // ----------------------------------------
  localparam logic [3:0] TYPE_CODE_RST = 4'h6;  // Device-type code, value arbitrary
  localparam int TYPE_MSB         = 7;        // Type code field top bit
  localparam int SEL_MSB          = 3;        // Select field top bit
  localparam int SEL_LSB          = 1;        // Select field bottom bit
  localparam int RW_BIT           = 0;        // Read/write flag bit
  localparam logic [2:0] SEL_NONE = 3'h0;     // Select code without select pins
  localparam int FIFO_DEPTH       = 4;        // Received-byte buffer depth
endpackage

// ==== eepin_top.sv ====
// Pin front end of a two-wire serial EEPROM slave: filtering, framing,
// address match, acknowledge, write protect, and byte transmit.
// Assumes bus pins are asynchronous to clk_i; a memory core sits on the
// user side and consumes received bytes and supplies read bytes.

// Overview of operation
// - Sample on SCL rise, change after fall
// - SDA open drain: pull low, never high
// - Match three select bits against select inputs
// - Floating select inputs count as low
// - Variants without select pins answer 000
// - Upper four bits must match type code
// - Write protect high refuses all writes
// - Floating write protect counts as low
// - Variants without protect pin always allow writes
// - Protect strobed before first data byte
// - No address acknowledge while write busy
// - Ready within 1 ms after supply stable
// - Standby above trigger, reset below it
// - Reject bus pulses of 100 ns or less
module eepin_top #(
  parameter int         POWERUP_CYCLES = eepin_pkg::POWERUP_CYC, // Readiness delay
  parameter bit         HAS_SEL_PINS   = 1'b1,   // Package has select inputs
  parameter bit         HAS_WP_PIN     = 1'b1,   // Package has protect input
  parameter logic [3:0] TYPE_CODE      = eepin_pkg::TYPE_CODE_RST
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       por_ok_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [2:0] select_i,
  input  wire logic       wp_i,
  input  wire logic       write_busy_i,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_first_o,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_take_o,
  output logic            selected_o,
  output logic            reading_o,
  output logic            stop_o,
  output logic            ready_o
);
  initial begin
    if (POWERUP_CYCLES < 1) begin
      $error("eepin_top: POWERUP_CYCLES must be at least 1");
    end
  end

  localparam int GW = $clog2(eepin_pkg::GLITCH_CYC + 1);
  localparam int PW = $clog2(POWERUP_CYCLES + 1);

  // ----------------------------------------
  // Synchronisers and glitch filters
  // ----------------------------------------
  logic [1:0] scl_sync;              // Two-flop chain for SCL
  logic [1:0] sda_sync;              // Two-flop chain for SDA
  logic [1:0] wp_sync;               // Two-flop chain for protect
  logic [1:0] por_sync;              // Two-flop chain for supply good
  logic [2:0] sel_meta;              // First stage for select inputs
  logic [2:0] sel_sync;              // Second stage for select inputs
  logic       scl_f;                 // Filtered SCL
  logic       sda_f;                 // Filtered SDA
  logic       next_scl_f;
  logic       next_sda_f;
  logic [GW-1:0] scl_cnt;            // Stability counter for SCL
  logic [GW-1:0] sda_cnt;            // Stability counter for SDA
  logic [GW-1:0] next_scl_cnt;
  logic [GW-1:0] next_sda_cnt;

  // Pins cross into clk_i; only the second stage is read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync  <= 2'h0;
      por_sync <= 2'h0;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      wp_sync  <= {wp_sync[0], wp_i};
      por_sync <= {por_sync[0], por_ok_i};
      sel_meta <= select_i;
      sel_sync <= sel_meta;
    end
  end

  // A level only passes once stable longer than the glitch width
  always_comb begin
    next_scl_f   = scl_f;
    next_sda_f   = sda_f;
    next_scl_cnt = '0;
    next_sda_cnt = '0;
    if (scl_sync[1] != scl_f) begin
      next_scl_cnt = scl_cnt + 1'b1;
      if (scl_cnt == GW'(eepin_pkg::GLITCH_CYC - 1)) begin
        next_scl_f   = scl_sync[1];
        next_scl_cnt = '0;
      end
    end
    if (sda_sync[1] != sda_f) begin
      next_sda_cnt = sda_cnt + 1'b1;
      if (sda_cnt == GW'(eepin_pkg::GLITCH_CYC - 1)) begin
        next_sda_f   = sda_sync[1];
        next_sda_cnt = '0;
      end
    end
  end

  // Filter registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_f   <= 1'b1;
      sda_f   <= 1'b1;
      scl_cnt <= '0;
      sda_cnt <= '0;
    end else begin
      scl_f   <= next_scl_f;
      sda_f   <= next_sda_f;
      scl_cnt <= next_scl_cnt;
      sda_cnt <= next_sda_cnt;
    end
  end

  // ----------------------------------------
  // Power-up readiness
  // ----------------------------------------
  logic [PW-1:0] pu_cnt;             // Cycles since supply good
  logic [PW-1:0] next_pu_cnt;
  logic          ready;              // Device accepts bus traffic
  logic          next_ready;

  // Supply drop returns to reset; readiness waits the power-up delay
  always_comb begin
    next_pu_cnt = pu_cnt;
    next_ready  = ready;
    if (!por_sync[1]) begin
      next_pu_cnt = '0;
      next_ready  = 1'b0;
    end else if (!ready) begin
      next_pu_cnt = pu_cnt + 1'b1;
      if (pu_cnt == PW'(POWERUP_CYCLES - 1)) begin
        next_ready = 1'b1;
      end
    end
  end

  // Readiness registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pu_cnt <= '0;
      ready  <= 1'b0;
    end else begin
      pu_cnt <= next_pu_cnt;
      ready  <= next_ready;
    end
  end

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  logic scl_d;                       // Filtered SCL one cycle ago
  logic sda_d;                       // Filtered SDA one cycle ago
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Edges of filtered lines only, so glitches make no events
  always_comb begin
    scl_rise = scl_f && !scl_d;
    scl_fall = !scl_f && scl_d;
    start_ev = scl_f && scl_d && sda_d && !sda_f;
    stop_ev  = scl_f && scl_d && !sda_d && sda_f;
  end

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  typedef enum logic [2:0] {
    EEPIN_IDLE, EEPIN_ADDR, EEPIN_ADDR_ACK, EEPIN_RX, EEPIN_RX_ACK,
    EEPIN_TX, EEPIN_TX_ACK
  } eepin_state_t;

  eepin_state_t state;
  eepin_state_t next_state;
  logic [7:0]   shreg;               // Shift register, both directions
  logic [7:0]   next_shreg;
  logic [3:0]   bitcnt;              // Bits seen in current byte
  logic [3:0]   next_bitcnt;
  logic         drive_low;           // Pull SDA low
  logic         next_drive_low;
  logic         first_data;          // Flags received bytes up to the first data byte
  logic         next_first_data;
  logic [1:0]   addr_bytes;          // Word address bytes still expected
  logic [1:0]   next_addr_bytes;
  logic         wp_held;             // Protect level strobed for this write
  logic         next_wp_held;
  logic         push;                // Offer received byte to buffer
  logic         next_push;
  logic         take;                // Pulse to fetch next read byte
  logic         next_take;
  logic         fifo_in_ready;
  logic [2:0]   own_sel;             // Own select code
  logic         addr_ok;
  logic         is_data;
  logic         wp_eff;

  // Address and protect decode
  always_comb begin
    own_sel = HAS_SEL_PINS ? sel_sync : eepin_pkg::SEL_NONE;
    wp_eff  = HAS_WP_PIN ? wp_sync[1] : 1'b0;
    addr_ok = (shreg[eepin_pkg::TYPE_MSB -: 4] == TYPE_CODE)
           && (shreg[eepin_pkg::SEL_MSB:eepin_pkg::SEL_LSB] == own_sel)
           && !write_busy_i;
    is_data = (addr_bytes == 2'h0);
  end

  // Next state of the byte engine
  always_comb begin
    next_state      = state;
    next_shreg      = shreg;
    next_bitcnt     = bitcnt;
    next_drive_low  = drive_low;
    next_first_data = first_data;
    next_addr_bytes = addr_bytes;
    next_wp_held    = wp_held;
    next_push       = push && !fifo_in_ready;
    next_take       = 1'b0;
    if (!ready) begin
      next_state     = EEPIN_IDLE;
      next_drive_low = 1'b0;
      next_push      = 1'b0;
    end else if (start_ev) begin
      next_state     = EEPIN_ADDR;
      next_bitcnt    = 4'h0;
      next_drive_low = 1'b0;
    end else if (stop_ev) begin
      next_state     = EEPIN_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        EEPIN_IDLE: begin
          next_drive_low = 1'b0;
        end
        EEPIN_ADDR, EEPIN_RX: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            if (state == EEPIN_ADDR) begin
              if (addr_ok) begin
                next_state     = EEPIN_ADDR_ACK;
                next_drive_low = 1'b1;
                if (!shreg[eepin_pkg::RW_BIT]) begin
                  next_addr_bytes = 2'h2;
                  next_first_data = 1'b1;
                end
              end else begin
                next_state = EEPIN_IDLE;
              end
            end else begin
              if (is_data && wp_held) begin
                next_state = EEPIN_IDLE;
              end else begin
                next_state     = EEPIN_RX_ACK;
                next_drive_low = 1'b1;
                next_push      = 1'b1;
              end
            end
          end
        end
        EEPIN_ADDR_ACK: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            if (shreg[eepin_pkg::RW_BIT]) begin
              next_state     = EEPIN_TX;
              next_shreg     = tx_data_i;
              next_take      = 1'b1;
              next_drive_low = !tx_data_i[7];
            end else begin
              next_state = EEPIN_RX;
            end
          end
        end
        EEPIN_RX_ACK: begin
          if (scl_fall) begin
            next_drive_low = 1'b0;
            next_state     = EEPIN_RX;
            if (is_data) begin
              next_first_data = 1'b0;
            end else begin
              next_addr_bytes = addr_bytes - 2'h1;
              next_wp_held    = (addr_bytes == 2'h1) ? wp_eff : wp_held;
            end
          end
        end
        EEPIN_TX: begin
          if (scl_fall) begin
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              next_state     = EEPIN_TX_ACK;
              next_bitcnt    = 4'h0;
              next_drive_low = 1'b0;
            end else begin
              next_shreg     = {shreg[6:0], 1'b1};
              next_drive_low = !shreg[6];
            end
          end
        end
        EEPIN_TX_ACK: begin
          if (scl_rise) begin
            if (sda_f) begin
              next_state = EEPIN_IDLE;
            end else begin
              next_shreg = tx_data_i;
              next_take  = 1'b1;
            end
          end
          if (scl_fall && state == next_state) begin
            next_state     = EEPIN_TX;
            next_drive_low = !shreg[7];
          end
        end
        default: begin
          next_state = EEPIN_IDLE;
        end
      endcase
    end
  end

  // Byte engine registers; SCL itself is never driven
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state      <= EEPIN_IDLE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      drive_low  <= 1'b0;
      first_data <= 1'b0;
      addr_bytes <= 2'h0;
      wp_held    <= 1'b0;
      push       <= 1'b0;
      take       <= 1'b0;
    end else begin
      state      <= next_state;
      shreg      <= next_shreg;
      bitcnt     <= next_bitcnt;
      drive_low  <= next_drive_low;
      first_data <= next_first_data;
      addr_bytes <= next_addr_bytes;
      wp_held    <= next_wp_held;
      push       <= next_push;
      take       <= next_take;
    end
  end

  // ----------------------------------------
  // Received byte buffer and outputs
  // ----------------------------------------
  logic [8:0] fifo_out;
  logic       fifo_valid;

  eepin_fifo #(
    .WIDTH (9),
    .DEPTH (eepin_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_data_i   ({first_data, shreg}),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (rx_ready_i && !rx_valid_o)
  );

  // Output registers; a buffered word is held until rx_ready_i
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_first_o <= 1'b0;
      rx_valid_o <= 1'b0;
      tx_take_o  <= 1'b0;
      selected_o <= 1'b0;
      reading_o  <= 1'b0;
      stop_o     <= 1'b0;
      ready_o    <= 1'b0;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_o   <= next_drive_low;
      if (rx_valid_o && rx_ready_i) begin
        rx_valid_o <= 1'b0;
      end else if (!rx_valid_o && fifo_valid && rx_ready_i) begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= fifo_out[7:0];
        rx_first_o <= fifo_out[8];
      end
      tx_take_o  <= take;
      selected_o <= (state != EEPIN_IDLE) && (state != EEPIN_ADDR);
      reading_o  <= (state == EEPIN_TX) || (state == EEPIN_TX_ACK);
      stop_o     <= stop_ev && ready;
      ready_o    <= ready;
    end
  end
endmodule
